// ===== srxd_defines.vh
/*
 * Constants for the chained receive DMA channel: register indices,
 * field positions, descriptor layout and state budgets.
 * Assumes one state equals one clock period of the system clock.
 */
`ifndef SRXD_DEFINES_VH
`define SRXD_DEFINES_VH

// Register indices on the plain register port
`define SRXD_A_CBASE    8'h00
`define SRXD_A_CURDESC  8'h01
`define SRXD_A_ENDDESC  8'h02
`define SRXD_A_BUFLEN   8'h03
`define SRXD_A_REMAIN   8'h04
`define SRXD_A_BUFADDR  8'h05
`define SRXD_A_MODE     8'h06
`define SRXD_A_STATUS   8'h07
`define SRXD_A_IENABLE  8'h08
`define SRXD_A_FCOUNT   8'h09
`define SRXD_A_CMD      8'h0a
`define SRXD_A_PRIO     8'h0b

// Mode register fields
`define SRXD_B_MULTI    0
`define SRXD_B_CHAIN    1
`define SRXD_B_FCEN     2
`define SRXD_B_TXTIME   3

// Status and interrupt enable fields
`define SRXD_B_DONE     7
`define SRXD_B_EOF      6
`define SRXD_B_BOVER    5
`define SRXD_B_COVER    4
`define SRXD_B_ENABLE   1
`define SRXD_B_BUSY     0

// Command fields
`define SRXD_B_ABORT    0
`define SRXD_B_CCLR     1

// Fixed channel priority, highest first: 0,1,2,3 in two-bit codes
`define SRXD_PRIO_FIXED 8'h1b

// Descriptor word offsets
`define SRXD_D_LINK     16'h0000
`define SRXD_D_BPLO     16'h0002
`define SRXD_D_BPHI     16'h0004
`define SRXD_D_LEN      16'h0006
`define SRXD_D_STAT     16'h0008

// Budgets in states (one state per clock)
`define SRXD_T_MEM      8'd3
`define SRXD_T_SETUP    8'd18
`define SRXD_T_SETUP1   8'd23
`define SRXD_T_WB       8'd8
`define SRXD_T_WB1      8'd11
`define SRXD_T_SW       8'd26
`define SRXD_T_SW1      8'd34
`define SRXD_T_TXSU     8'd20
`define SRXD_T_TXSU1    8'd32
`define SRXD_T_TXMID    8'd21
`define SRXD_T_TXMID1   8'd33
`define SRXD_T_TXEND    8'd25
`define SRXD_T_TXEND1   8'd37

// Frame-end counter limit
`define SRXD_FCT_MAX    4'hf

`endif

// ===== srxd_flag.v
/*
 * Sticky status flag: set by hardware, cleared by software.
 * Assumes set and clear are one-cycle strobes on clk.
 */
`timescale 1ns/1ps
module srxd_flag (
    input  wire clk,
    input  wire rstn,
    input  wire set,
    input  wire clr,
    output reg  q
);

    // Set wins over a clear in the same cycle
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            q <= 1'b0;
        end else if (set) begin
            q <= 1'b1;
        end else if (clr) begin
            q <= 1'b0;
        end
    end

endmodule // srxd_flag

// ===== srxd_stimer.v
/*
 * State counter for the channel phases.
 * Assumes clear pulses on every phase change and a low run freezes it.
 */
`timescale 1ns/1ps
module srxd_stimer #(
    parameter W = 8
) (
    input  wire         clk,
    input  wire         rstn,
    input  wire         clear,
    input  wire         run,
    output reg  [W-1:0] count
);

    // Counts states inside a phase, holds while suspended
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count <= {W{1'b0}};
        end else if (clear) begin
            count <= {W{1'b0}};
        end else if (run) begin
            count <= count + {{(W-1){1'b0}}, 1'b1};
        end
    end

endmodule // srxd_stimer

// ===== srxd_top.v
/*
 * Chained-block receive DMA channel: moves serial bytes or words into
 * memory through a chain of descriptors, with frame counting and errors.
 * Assumes a zero-wait memory with read data valid in the third state of
 * a read, and a serial source that holds rx_req until rx_ack.
 */
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "srxd_defines.vh"
module srxd_top (
    input  wire        clk,
    input  wire        rstn,
    input  wire [1:0]  cpu_mode,
    input  wire [7:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata,
    input  wire        rx_req,
    input  wire [15:0] rx_data,
    input  wire        rx_word,
    input  wire        rx_eof,
    output reg         rx_ack,
    output reg         mem_cs,
    output reg         mem_we,
    output reg         mem_word,
    output reg  [23:0] mem_addr,
    output reg  [15:0] mem_wdata,
    input  wire [15:0] mem_rdata,
    output reg         error_irq,
    output reg         normal_end_irq
);

    localparam [2:0] ST_INIT   = 3'd0;
    localparam [2:0] ST_SETUP  = 3'd1;
    localparam [2:0] ST_XFER   = 3'd2;
    localparam [2:0] ST_WRITE  = 3'd3;
    localparam [2:0] ST_SWITCH = 3'd4;
    localparam [2:0] ST_HALT   = 3'd5;

    reg  [2:0]  state;
    reg  [2:0]  next_state;
    wire [7:0]  scnt;
    reg  [7:0]  chain_base_byte;
    reg  [15:0] current_descriptor_reg;
    reg  [15:0] end_descriptor_reg;
    reg  [15:0] buffer_length_reg;
    reg  [15:0] remaining_bytes_reg;
    reg  [23:0] buffer_address_field;
    reg  [15:0] next_link_field;
    reg  [15:0] received_length_field;
    reg         multi_frame_select;
    reg         transfer_mode_select;
    reg         fct_enable;
    reg         tx_timing;
    reg         channel_enable_bit;
    reg  [3:0]  frame_end_counter;
    reg  [3:0]  next_fct;
    reg         eof_pend;
    reg         sw_pend;
    reg         counter_overflow_enable;
    reg         buffer_over_enable;
    reg         end_of_frame_enable;
    reg         transfer_done_enable;
    wire        counter_overflow_flag;
    wire        buffer_over_flag;
    wire        end_of_frame_flag;
    wire        transfer_done_flag;
    reg         dec_cs;
    reg         dec_we;
    reg  [15:0] dec_off;
    reg  [15:0] dec_wd;

    // Register port decode
    wire wr_stat   = reg_wr & (reg_addr == `SRXD_A_STATUS);
    wire wr_cmd    = reg_wr & (reg_addr == `SRXD_A_CMD);
    wire cmd_abort = wr_cmd & reg_wdata[`SRXD_B_ABORT];
    wire cmd_cclr  = wr_cmd & reg_wdata[`SRXD_B_CCLR];
    wire eof_w1c   = wr_stat & reg_wdata[`SRXD_B_EOF];

    // Channel runs only while enabled; clearing the enable freezes it
    wire run = channel_enable_bit;
    wire m1  = (cpu_mode == 2'd1);

    // Phase budgets per processor mode and timing direction
    wire [7:0] su_len = tx_timing ? (m1 ? `SRXD_T_TXSU1 : `SRXD_T_TXSU)
                                  : (m1 ? `SRXD_T_SETUP1 : `SRXD_T_SETUP);
    wire [7:0] wb_len = m1 ? `SRXD_T_WB1 : `SRXD_T_WB;
    wire [7:0] tx_sw  = eof_pend ? (m1 ? `SRXD_T_TXEND1 : `SRXD_T_TXEND)
                                 : (m1 ? `SRXD_T_TXMID1 : `SRXD_T_TXMID);
    wire [7:0] sw_len = tx_timing ? tx_sw : (m1 ? `SRXD_T_SW1 : `SRXD_T_SW);

    // Phase end strobes
    wire su_end = (state == ST_SETUP) & run & (scnt == su_len - 8'd1);
    wire sw_mid = (state == ST_SWITCH) & run & (scnt == wb_len - 8'd1);
    wire sw_end = (state == ST_SWITCH) & run & (scnt == sw_len - 8'd1);
    wire wr_end = (state == ST_WRITE) & run & (scnt == `SRXD_T_MEM - 8'd1);
    wire at_req = (state == ST_XFER) & run & rx_req;
    wire meet   = (current_descriptor_reg == end_descriptor_reg);
    wire take   = at_req & ~meet;
    wire block  = at_req & meet;
    wire frame_evt = sw_end & eof_pend;
    wire ovf_evt   = frame_evt & fct_enable & (frame_end_counter == `SRXD_FCT_MAX);
    wire single_done = frame_evt & ~multi_frame_select;
    wire [15:0] step = rx_word ? 16'd2 : 16'd1;

    // Descriptor read window inside setup and switch phases
    wire [7:0] rbase = (state == ST_SWITCH) ? wb_len : 8'd0;
    wire       in_rd = (scnt >= rbase);
    wire [7:0] rcyc  = scnt - rbase;
    wire       cap   = run & in_rd & ((state == ST_SETUP) | (state == ST_SWITCH));

    // Phase state counter
    srxd_stimer #(
        .W (8)
    ) u_stimer (
        .clk   (clk),
        .rstn  (rstn),
        .clear (next_state != state),
        .run   (run),
        .count (scnt)
    );

    // Next channel state
    always @* begin
        next_state = state;
        case (state)
            ST_INIT: begin
                if (run & transfer_mode_select) next_state = ST_SETUP;
            end
            ST_SETUP: begin
                if (su_end) next_state = ST_XFER;
            end
            ST_XFER: begin
                if (take) next_state = ST_WRITE;
                else if (block) next_state = ST_HALT;
            end
            ST_WRITE: begin
                if (wr_end) next_state = sw_pend ? ST_SWITCH : ST_XFER;
            end
            ST_SWITCH: begin
                if (sw_end) begin
                    if (ovf_evt) next_state = ST_HALT;
                    else if (single_done) next_state = ST_INIT;
                    else next_state = ST_XFER;
                end
            end
            ST_HALT: begin
                next_state = ST_HALT;
            end
            default: begin
                next_state = ST_INIT;
            end
        endcase
        if (cmd_abort) next_state = ST_INIT;
    end

    // Descriptor access decode for the current state count
    always @* begin
        dec_cs  = 1'b0;
        dec_we  = 1'b0;
        dec_off = `SRXD_D_LINK;
        dec_wd  = 16'h0000;
        if ((state == ST_SWITCH) && (scnt < 8'd6)) begin
            dec_cs  = 1'b1;
            dec_we  = 1'b1;
            dec_off = (scnt < 8'd3) ? `SRXD_D_LEN : `SRXD_D_STAT;
            dec_wd  = (scnt < 8'd3) ? received_length_field : {8'h00, eof_pend, 7'h00};
        end else if (cap && (rcyc < 8'd9)) begin
            dec_cs  = 1'b1;
            if (rcyc < 8'd3) dec_off = `SRXD_D_LINK;
            else if (rcyc < 8'd6) dec_off = `SRXD_D_BPLO;
            else dec_off = `SRXD_D_BPHI;
        end
    end

    // Frame-end counter next value
    always @* begin
        next_fct = frame_end_counter;
        if (cmd_cclr | ovf_evt) begin
            next_fct = 4'h0;
        end else if (fct_enable) begin
            if (frame_evt & ~eof_w1c) begin
                next_fct = frame_end_counter + 4'h1;
            end else if (eof_w1c & ~frame_evt & (frame_end_counter != 4'h0)) begin
                next_fct = frame_end_counter - 4'h1;
            end
        end
    end

    // Sticky interrupt sources
    srxd_flag u_cof (
        .clk  (clk),
        .rstn (rstn),
        .set  (ovf_evt),
        .clr  (wr_stat & reg_wdata[`SRXD_B_COVER]),
        .q    (counter_overflow_flag)
    );

    srxd_flag u_bof (
        .clk  (clk),
        .rstn (rstn),
        .set  (block),
        .clr  (wr_stat & reg_wdata[`SRXD_B_BOVER]),
        .q    (buffer_over_flag)
    );

    srxd_flag u_eom (
        .clk  (clk),
        .rstn (rstn),
        .set  (frame_evt | (fct_enable & (next_fct != 4'h0))),
        .clr  (eof_w1c | cmd_cclr),
        .q    (end_of_frame_flag)
    );

    srxd_flag u_eot (
        .clk  (clk),
        .rstn (rstn),
        .set  (single_done),
        .clr  (wr_stat & reg_wdata[`SRXD_B_DONE]),
        .q    (transfer_done_flag)
    );

    // Interrupt requests stay up in any channel state until cleared
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            error_irq      <= 1'b0;
            normal_end_irq <= 1'b0;
        end else begin
            error_irq      <= (counter_overflow_flag & counter_overflow_enable) |
                              (buffer_over_flag & buffer_over_enable);
            normal_end_irq <= (end_of_frame_flag & end_of_frame_enable) |
                              (transfer_done_flag & transfer_done_enable);
        end
    end

    // Control registers, channel state and buffer walk
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state                   <= ST_INIT;
            chain_base_byte         <= 8'h00;
            current_descriptor_reg  <= 16'h0000;
            end_descriptor_reg      <= 16'h0000;
            buffer_length_reg       <= 16'h0000;
            remaining_bytes_reg     <= 16'h0000;
            buffer_address_field    <= 24'h000000;
            next_link_field         <= 16'h0000;
            received_length_field   <= 16'h0000;
            multi_frame_select      <= 1'b0;
            transfer_mode_select    <= 1'b0;
            fct_enable              <= 1'b0;
            tx_timing               <= 1'b0;
            channel_enable_bit      <= 1'b0;
            frame_end_counter       <= 4'h0;
            eof_pend                <= 1'b0;
            sw_pend                 <= 1'b0;
            counter_overflow_enable <= 1'b0;
            buffer_over_enable      <= 1'b0;
            end_of_frame_enable     <= 1'b0;
            transfer_done_enable    <= 1'b0;
            rx_ack                  <= 1'b0;
        end else begin
            state             <= next_state;
            frame_end_counter <= next_fct;
            rx_ack            <= take;
            if (reg_wr) begin
                case (reg_addr)
                    `SRXD_A_CBASE:   chain_base_byte <= reg_wdata[7:0];
                    `SRXD_A_CURDESC: current_descriptor_reg <= reg_wdata[15:0];
                    `SRXD_A_ENDDESC: end_descriptor_reg <= reg_wdata[15:0];
                    `SRXD_A_BUFLEN:  buffer_length_reg <= reg_wdata[15:0];
                    `SRXD_A_MODE: begin
                        multi_frame_select   <= reg_wdata[`SRXD_B_MULTI];
                        transfer_mode_select <= reg_wdata[`SRXD_B_CHAIN];
                        fct_enable           <= reg_wdata[`SRXD_B_FCEN];
                        tx_timing            <= reg_wdata[`SRXD_B_TXTIME];
                    end
                    `SRXD_A_STATUS:  channel_enable_bit <= reg_wdata[`SRXD_B_ENABLE];
                    `SRXD_A_IENABLE: begin
                        transfer_done_enable    <= reg_wdata[`SRXD_B_DONE];
                        end_of_frame_enable     <= reg_wdata[`SRXD_B_EOF];
                        buffer_over_enable      <= reg_wdata[`SRXD_B_BOVER];
                        counter_overflow_enable <= reg_wdata[`SRXD_B_COVER];
                    end
                    default: begin
                    end
                endcase
            end
            // Hardware stops win over a software write in the same cycle
            if (block | ovf_evt | single_done | cmd_abort) begin
                channel_enable_bit <= 1'b0;
            end
            // Descriptor fields captured in the third state of each read
            if (cap && (rcyc == 8'd3)) next_link_field <= mem_rdata;
            if (cap && (rcyc == 8'd6)) buffer_address_field[15:0] <= mem_rdata;
            if (cap && (rcyc == 8'd9)) buffer_address_field[23:16] <= mem_rdata[7:0];
            if (sw_mid) current_descriptor_reg <= next_link_field;
            if (take) begin
                buffer_address_field  <= buffer_address_field + {8'h00, step};
                remaining_bytes_reg   <= (remaining_bytes_reg > step) ?
                                         (remaining_bytes_reg - step) : 16'h0000;
                received_length_field <= received_length_field + step;
                sw_pend               <= rx_eof | (remaining_bytes_reg <= step);
                eof_pend              <= rx_eof;
            end
            if (su_end | sw_end) begin
                remaining_bytes_reg   <= buffer_length_reg;
                received_length_field <= 16'h0000;
                sw_pend               <= 1'b0;
                eof_pend              <= 1'b0;
            end
        end
    end

    // Memory bus cycles: data writes and descriptor accesses
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mem_cs    <= 1'b0;
            mem_we    <= 1'b0;
            mem_word  <= 1'b0;
            mem_addr  <= 24'h000000;
            mem_wdata <= 16'h0000;
        end else if (cmd_abort) begin
            mem_cs <= 1'b0;
            mem_we <= 1'b0;
        end else if (take) begin
            mem_cs    <= 1'b1;
            mem_we    <= 1'b1;
            mem_word  <= rx_word;
            mem_addr  <= buffer_address_field;
            mem_wdata <= rx_data;
        end else if (wr_end) begin
            mem_cs <= 1'b0;
            mem_we <= 1'b0;
        end else if (run && ((state == ST_SETUP) || (state == ST_SWITCH))) begin
            mem_cs    <= dec_cs;
            mem_we    <= dec_we;
            mem_word  <= 1'b1;
            mem_addr  <= {chain_base_byte, current_descriptor_reg + dec_off};
            mem_wdata <= dec_wd;
        end
    end

    // Read data, valid only in the cycle after the read strobe
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                `SRXD_A_CBASE:   reg_rdata <= {24'h000000, chain_base_byte};
                `SRXD_A_CURDESC: reg_rdata <= {16'h0000, current_descriptor_reg};
                `SRXD_A_ENDDESC: reg_rdata <= {16'h0000, end_descriptor_reg};
                `SRXD_A_BUFLEN:  reg_rdata <= {16'h0000, buffer_length_reg};
                `SRXD_A_REMAIN:  reg_rdata <= {16'h0000, remaining_bytes_reg};
                `SRXD_A_BUFADDR: reg_rdata <= {8'h00, buffer_address_field};
                `SRXD_A_MODE:    reg_rdata <= {28'h0000000, tx_timing, fct_enable,
                                               transfer_mode_select, multi_frame_select};
                `SRXD_A_STATUS:  reg_rdata <= {24'h000000, transfer_done_flag,
                                               end_of_frame_flag, buffer_over_flag,
                                               counter_overflow_flag, 2'b00,
                                               channel_enable_bit, (state != ST_INIT)};
                `SRXD_A_IENABLE: reg_rdata <= {24'h000000, transfer_done_enable,
                                               end_of_frame_enable, buffer_over_enable,
                                               counter_overflow_enable, 4'h0};
                `SRXD_A_FCOUNT:  reg_rdata <= {28'h0000000, frame_end_counter};
                `SRXD_A_PRIO:    reg_rdata <= {24'h000000, `SRXD_PRIO_FIXED};
                default:         reg_rdata <= 32'h00000000;
            endcase
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

endmodule // srxd_top

// ===== srxd_props.sv
/* Checker for srxd_top: unit writes, handshake, descriptor region,
   fixed priority and sticky requests. Bound to every srxd_top. */
`timescale 1ns/1ps
`include "srxd_defines.vh"
module srxd_props (
    input wire        clk,
    input wire        rstn,
    input wire [7:0]  reg_addr,
    input wire [31:0] reg_wdata,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [31:0] reg_rdata,
    input wire        rx_req,
    input wire        rx_ack,
    input wire        mem_cs,
    input wire        mem_we,
    input wire [23:0] mem_addr,
    input wire [15:0] mem_wdata,
    input wire        error_irq,
    input wire        normal_end_irq
);
    reg [7:0] base_q;

    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    // Shadow of the descriptor region byte
    always @(posedge clk or negedge rstn) begin
        if (!rstn)
            base_q <= 8'h00;
        else if (reg_wr && reg_addr == `SRXD_A_CBASE)
            base_q <= reg_wdata[7:0];
    end

    // One unit per three-state write
    ack_gap_a: assert property (rx_ack |=> !rx_ack [*3])
        else $error("unit taken inside a write");
    wr_cycle_a: assert property (rx_ack |-> (mem_cs && mem_we) [*3])
        else $error("unit write not three states");
    unit_hold_a: assert property (rx_ack |=> ($stable(mem_addr) && $stable(mem_wdata)) [*2])
        else $error("unit write moved");
    ack_cause_a: assert property (rx_ack |-> $past(rx_req))
        else $error("ack without request");
    // Descriptor reads stay in the region
    fetch_base_a: assert property (mem_cs && !mem_we |-> mem_addr[23:16] == base_q)
        else $error("descriptor read outside region");
    prio_read_a: assert property ($past(reg_rd) && $past(reg_addr) == `SRXD_A_PRIO
        |-> reg_rdata == {24'h000000, `SRXD_PRIO_FIXED})
        else $error("priority not fixed");
    // Requests drop only after software writes
    err_hold_a: assert property ($fell(error_irq) |-> $past(reg_wr) || $past(reg_wr, 2))
        else $error("error request dropped alone");
    end_hold_a: assert property ($fell(normal_end_irq) |-> $past(reg_wr) || $past(reg_wr, 2))
        else $error("end request dropped alone");
endmodule // srxd_props

bind srxd_top srxd_props u_srxd_props (.*);

// ===== srxd_mem_model.sv
/* Memory partner: one region of 64K 16-bit cells, zero wait.
   The bench preloads descriptors through w. */
`timescale 1ns/1ps
module srxd_mem_model (
    input  wire        clk,
    input  wire        mem_cs,
    input  wire        mem_we,
    input  wire [23:0] mem_addr,
    input  wire [15:0] mem_wdata,
    output wire [15:0] mem_rdata
);
    reg [15:0] w [0:65535];
    reg        tog = 1'b0;

    // Store each write beat in the single region
    always @(posedge clk) begin
        tog <= ~tog;
        if (mem_cs && mem_we)
            w[mem_addr[15:0]] <= mem_wdata;
    end
    // Idle read bus flips each cycle so stale data never passes
    assign mem_rdata = (mem_cs && !mem_we) ? w[mem_addr[15:0]] : {16{tog}} ^ 16'h5a5a;
endmodule // srxd_mem_model

// ===== tb_srxd_top.sv
/* Bench for srxd_top: reset values, multi-frame run, end refusal,
   abort, single frame in mode 1, transmit budgets, counter overflow.
   Memory is srxd_mem_model. */
`timescale 1ns/1ps
`include "srxd_defines.vh"
module tb_srxd_top;
    reg         clk = 1'h0, rstn = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
    reg         rx_req = 1'h0, rx_word = 1'h0, rx_eof = 1'h0;
    reg  [1:0]  cpu_mode = 2'h0;
    reg  [7:0]  reg_addr = 8'h00;
    reg  [31:0] reg_wdata = 32'h0, v;
    reg  [15:0] rx_data = 16'h0;
    reg  [39:0] rows [0:6];
    wire [31:0] reg_rdata;
    wire [23:0] mem_addr;
    wire [15:0] mem_wdata, mem_rdata;
    wire        rx_ack, mem_cs, mem_we, error_irq, normal_end_irq;
    integer     n_errors = 0, checks_done = 0, cyc = 0, csc = 0, t0, c0, i, g, n, k;

    srxd_top u_srxd_top (.*, .mem_word());
    srxd_mem_model u_srxd_mem_model (.*);

    // Clock, cycle count and memory activity count
    initial forever #2.5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (mem_cs) csc <= csc + 1;
    end

    task chk(input string nm, input [31:0] got, input [31:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("[ERR] %0s expected %h seen %h", nm, exp, got);
            end
        end
    endtask
    task stop_test;
        begin
            $display("checks %0d errors %0d", checks_done, n_errors);
            if (n_errors == 0 && checks_done > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        begin
            reg_addr <= a; reg_wdata <= d; reg_wr <= 1'h1;
            @(posedge clk); reg_wr <= 1'h0; @(posedge clk);
        end
    endtask
    task rd(input [7:0] a, output [31:0] d);
        begin
            reg_addr <= a; reg_rd <= 1'h1;
            @(posedge clk); reg_rd <= 1'h0; @(posedge clk);
            d = reg_rdata;
        end
    endtask
    // Wait for the normal-end request under a bound; the live pin is watched
    task await;
        begin
            k = 0;
            while (normal_end_irq !== 1'h1 && k < 100) begin k = k + 1; @(posedge clk); end
            if (k == 100) begin n_errors = n_errors + 1; stop_test; end
        end
    endtask
    // Offer one byte; log spacing and memory activity since the last unit
    task send(input [7:0] d, input e);
        begin
            rx_data <= {8'h00, d}; rx_eof <= e; rx_req <= 1'h1;
            @(posedge clk);
            k = 0;
            while (rx_ack !== 1'h1 && k < 100) begin k = k + 1; @(posedge clk); end
            if (k == 100) begin n_errors = n_errors + 1; stop_test; end
            rx_req <= 1'h0; rx_data <= ~{8'h00, d};
            g = cyc - t0; n = csc - c0; t0 = cyc; c0 = csc;
            @(posedge clk);
        end
    endtask
    // Three-descriptor ring, buffers of two bytes, one three-byte frame
    task frame(input [1:0] cm, input [7:0] md, input integer su, input integer sw);
        begin
            for (i = 0; i < 3; i = i + 1) begin
                u_srxd_mem_model.w[16'h0100 + 16*i] = (i == 2) ? 16'h0100 : 16'h0110 + 16*i;
                u_srxd_mem_model.w[16'h0102 + 16*i] = 16'h2000 + 16'h1000 * i;
                u_srxd_mem_model.w[16'h0104 + 16*i] = 16'h0005;
            end
            cpu_mode <= cm;
            wr(`SRXD_A_MODE, md);
            wr(`SRXD_A_CBASE, 32'h05);
            wr(`SRXD_A_ENDDESC, 32'h0120);
            wr(`SRXD_A_CURDESC, 32'h0100);
            wr(`SRXD_A_BUFLEN, 32'h02);
            wr(`SRXD_A_IENABLE, 32'hf0);
            t0 = cyc; c0 = csc;
            wr(`SRXD_A_STATUS, 32'h02);
            send(8'ha1, 1'h0);
            chk("setup_gap", g, su);
            chk("setup_cs", n, 9);
            send(8'hb2, 1'h0);
            chk("unit_gap", g, 4);
            chk("unit_cs", n, 3);
            send(8'hc3, 1'h1);
            chk("switch_gap", g, sw);
            chk("switch_cs", n, 18);
            await;
            chk("data0", u_srxd_mem_model.w[16'h2000][7:0], 8'ha1);
            chk("data1", u_srxd_mem_model.w[16'h2001][7:0], 8'hb2);
            chk("data2", u_srxd_mem_model.w[16'h3000][7:0], 8'hc3);
            chk("len0", u_srxd_mem_model.w[16'h0106], 2);
            chk("len1", u_srxd_mem_model.w[16'h0116], 1);
            chk("stat1", u_srxd_mem_model.w[16'h0118], 16'h0080);
            rd(`SRXD_A_CURDESC, v);
            chk("cur_desc", v, 32'h0120);
        end
    endtask

    initial begin
        rows[0] = {`SRXD_A_MODE, 32'h0}; rows[1] = {`SRXD_A_STATUS, 32'h0};
        rows[2] = {`SRXD_A_IENABLE, 32'h0}; rows[3] = {`SRXD_A_FCOUNT, 32'h0};
        rows[4] = {`SRXD_A_PRIO, 32'h1b}; rows[5] = {`SRXD_A_CMD, 32'h0};
        rows[6] = {8'h30, 32'h0};
        repeat (2) @(posedge clk);
        rstn <= 1'h1;
        @(posedge clk);
        wr(`SRXD_A_PRIO, 32'hff);
        wr(`SRXD_A_FCOUNT, 32'hf);
        wr(8'h30, 32'hff);
        for (i = 0; i < 7; i = i + 1) begin
            rd(rows[i][39:32], v);
            chk("reset_reg", v, rows[i][31:0]);
        end
        frame(2'h0, 8'h07, 22, 30);
        rd(`SRXD_A_FCOUNT, v);
        chk("fcount", v, 1);
        rd(`SRXD_A_STATUS, v);
        chk("multi_status", v, 32'h43);
        chk("no_error", error_irq, 1'h0);
        // A further unit when current meets end must be refused
        rx_data <= 16'h00d4; rx_eof <= 1'h0; rx_req <= 1'h1;
        k = 0;
        repeat (40) begin @(posedge clk); if (rx_ack === 1'h1) k = k + 1; end
        rx_req <= 1'h0;
        chk("refused_ack", k, 0);
        rd(`SRXD_A_STATUS, v);
        chk("over_status", v, 32'h61);
        wr(`SRXD_A_CMD, 32'h01);
        rd(`SRXD_A_STATUS, v);
        chk("abort_status", v, 32'h60);
        chk("err_sticky", error_irq, 1'h1);
        wr(`SRXD_A_STATUS, 32'hf0);
        rd(`SRXD_A_STATUS, v);
        chk("clr_status", v, 32'h0);
        rd(`SRXD_A_FCOUNT, v);
        chk("fcount_dec", v, 0);
        chk("err_clr", error_irq, 1'h0);
        chk("end_clr", normal_end_irq, 1'h0);
        frame(2'h1, 8'h02, 27, 38);
        rd(`SRXD_A_STATUS, v);
        chk("single_status", v, 32'hc0);
        // Clear the sticky flags so the next frame's request is fresh
        wr(`SRXD_A_STATUS, 32'hf0);
        frame(2'h0, 8'h0a, 24, 25);
        rd(`SRXD_A_STATUS, v);
        chk("tx_status", v, 32'hc0);
        // Sixteen unserviced frames overflow the frame counter
        wr(`SRXD_A_STATUS, 32'hf0);
        wr(`SRXD_A_ENDDESC, 32'h0130);
        wr(`SRXD_A_MODE, 32'h07);
        wr(`SRXD_A_STATUS, 32'h02);
        for (i = 0; i < 16; i = i + 1) send(8'h55, 1'h1);
        repeat (40) @(posedge clk);
        rd(`SRXD_A_STATUS, v);
        chk("cof_status", v, 32'h51);
        rd(`SRXD_A_FCOUNT, v);
        chk("cof_fcount", v, 0);
        chk("cof_irq", error_irq, 1'h1);
        stop_test;
    end
endmodule // tb_srxd_top
